/* File: inc/dsrf_pkg.sv */
// shared constants and types of the two-sided register file datapath
// assumes one core clock; decode logic outside hands in one decoded op per unit
package dsrf_pkg;
   localparam int NSIDE = 2;
   localparam int NREG = 16;
   localparam int XLEN = 32;
   localparam int LLEN = 40;
   localparam int HI_W = 8;
   localparam int NUNIT = 8;
   localparam int NCTRL = 8;
   localparam int CIDX_W = 3;
   localparam int FETCH_W = 256;
   localparam int PADDR_W = 30;
   localparam int SOFF_W = 5;
   localparam int LOFF_W = 15;
   localparam int MUL_W = 16;
   localparam logic [PADDR_W-1:0] PKT_STEP = 30'h8;
   localparam logic [PADDR_W-1:0] FETCH_RST = 30'h0;
   // unit slot within a side; slot + 4 is the same unit on side b
   localparam int U_L = 0;
   localparam int U_S = 1;
   localparam int U_M = 2;
   localparam int U_D = 3;
   localparam int PER_SIDE = 4;
   localparam int MVC_UNIT = 5;
   localparam int LDK_UNIT = 7;

   typedef enum logic [4:0] {
      OP_NOP, OP_ADD, OP_SUB, OP_ADDL, OP_CMPGT, OP_CMPGTL, OP_AND, OP_OR, OP_XOR,
      OP_LMBD, OP_NORM, OP_NORML, OP_SHL, OP_SHR, OP_SHLL, OP_SHRL, OP_MVK, OP_BR,
      OP_MVCTO, OP_MVCFR, OP_MPY, OP_LDW, OP_STW, OP_LDWK, OP_STWK
   } dsrf_op_e;

   typedef struct packed {
      logic valid;
      logic cond_en;
      logic cond_b;
      logic [3:0] cond_reg;
      logic cond_z;
      dsrf_op_e op;
      logic [3:0] dst;
      logic [3:0] first_source_operand;
      logic [3:0] second_source_operand;
      logic x1;
      logic x2;
      logic [LOFF_W-1:0] imm;
   } dsrf_uop_s;

   typedef struct packed {
      logic req;
      logic we;
      logic [XLEN-1:0] addr;
      logic [XLEN-1:0] wdata;
   } dsrf_dmem_s;
endpackage : dsrf_pkg

/* File: design/dsrf_top.sv */
// two-sided general-purpose register file with its eight execution units
// assumes decoded ops arrive synchronous to core_clk, one per unit per cycle
// data memories answer a load with dmem_rvalid one or more cycles later
`timescale 1ns/1ps

module dsrf_top #(
   parameter int CTRL_REGS = dsrf_pkg::NCTRL
) (
   input logic core_clk,
   input logic nrst,
   input dsrf_pkg::dsrf_uop_s uop [dsrf_pkg::NUNIT],
   input logic fetch_valid,
   input logic [dsrf_pkg::FETCH_W-1:0] fetch_data,
   output logic [dsrf_pkg::PADDR_W-1:0] fetch_addr,
   output logic insn_valid,
   output logic [dsrf_pkg::NUNIT-1:0][dsrf_pkg::XLEN-1:0] insn,
   output dsrf_pkg::dsrf_dmem_s dmem [dsrf_pkg::NSIDE],
   input logic [dsrf_pkg::XLEN-1:0] dmem_rdata [dsrf_pkg::NSIDE],
   input logic dmem_rvalid [dsrf_pkg::NSIDE],
   output logic [dsrf_pkg::NUNIT-1:0] unit_fault
);
   import dsrf_pkg::*;

   logic [XLEN-1:0] rf_q [NSIDE][NREG];
   logic [XLEN-1:0] ctrl_q [CTRL_REGS];
   logic [PADDR_W-1:0] fetch_addr_q;
   logic insn_valid_q;
   logic [NUNIT-1:0][XLEN-1:0] insn_q;
   dsrf_dmem_s dmem_q [NSIDE];
   logic [NSIDE-1:0] ld_pend_q;
   logic [3:0] ld_dst_q [NSIDE];
   logic [NUNIT-1:0] fault_q;

   logic [NUNIT-1:0] fault;
   logic [NUNIT-1:0] ex;
   logic [NUNIT-1:0] wen;
   logic [NUNIT-1:0] wlong;
   logic [NUNIT-1:0] xuse;
   logic [XLEN-1:0] a1 [NUNIT];
   logic [LLEN-1:0] b2 [NUNIT];
   logic [LLEN-1:0] res [NUNIT];
   logic [XLEN-1:0] ea [NUNIT];
   logic br_d;
   logic [XLEN-1:0] br_tgt_d;

   function automatic logic legal(input int u, input dsrf_op_e op);
      case (u % PER_SIDE)
         U_L: legal = op inside {OP_ADD, OP_SUB, OP_ADDL, OP_CMPGT, OP_CMPGTL, OP_AND,
                                 OP_OR, OP_XOR, OP_LMBD, OP_NORM, OP_NORML};
         U_S: legal = op inside {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_SHL, OP_SHR,
                                 OP_SHLL, OP_SHRL, OP_MVK, OP_BR}
                      || (u == MVC_UNIT && op inside {OP_MVCTO, OP_MVCFR});
         U_M: legal = op == OP_MPY;
         default: legal = op inside {OP_ADD, OP_SUB, OP_LDW, OP_STW}
                          || (u == LDK_UNIT && op inside {OP_LDWK, OP_STWK});
      endcase
   endfunction : legal

   // long ops exist only on logic and shift units, the ones with 8-bit ports
   function automatic logic long_rd(input dsrf_op_e op);
      long_rd = op inside {OP_ADDL, OP_CMPGTL, OP_NORML, OP_SHLL, OP_SHRL};
   endfunction : long_rd

   function automatic logic long_wr(input dsrf_op_e op);
      long_wr = op inside {OP_ADDL, OP_SHLL, OP_SHRL};
   endfunction : long_wr

   // count leading bits equal to b over the low w bits of x
   function automatic logic [5:0] lead_cnt(input logic b, input logic [LLEN-1:0] x,
                                           input int w);
      logic [5:0] n;
      logic run;
      n = '0;
      run = 1'b1;
      for (int i = LLEN - 1; i >= 0; i--) begin
         if (i < w && run) begin
            if (x[i] == b) begin
               n = n + 6'h1;
            end else begin
               run = 1'b0;
            end
         end
      end
      return n;
   endfunction : lead_cnt

   always_comb begin
      logic [NSIDE-1:0] xtaken;
      logic [XLEN-1:0] cv;
      logic [3:0] ev;
      logic [3:0] od;
      logic [LOFF_W-1:0] off;
      xtaken = '0;
      cv = '0;
      ev = '0;
      od = '0;
      off = '0;
      br_d = 1'b0;
      br_tgt_d = '0;
      for (int u = 0; u < NUNIT; u++) begin
         // first cross user of a side wins, later ones fault this cycle;
         // one op taking both operands across would be two cross reads
         fault[u] = uop[u].valid && (!legal(u, uop[u].op)
                    || (uop[u].x1 && u % PER_SIDE != U_L)
                    || (uop[u].x2 && u % PER_SIDE == U_D)
                    || (uop[u].x2 && long_rd(uop[u].op))
                    || (uop[u].x1 && uop[u].x2)
                    || ((uop[u].x1 || uop[u].x2) && xtaken[u / PER_SIDE]));
         xuse[u] = uop[u].valid && !fault[u] && (uop[u].x1 || uop[u].x2);
         if (xuse[u]) begin
            xtaken[u / PER_SIDE] = 1'b1;
         end
         cv = rf_q[uop[u].cond_b][uop[u].cond_reg];
         ex[u] = uop[u].valid && !fault[u]
                 && (!uop[u].cond_en || ((cv != '0) ^ uop[u].cond_z));
         a1[u] = uop[u].x1 ? rf_q[1 - u / PER_SIDE][uop[u].first_source_operand]
                           : rf_q[u / PER_SIDE][uop[u].first_source_operand];
         ev = {uop[u].second_source_operand[3:1], 1'b0};
         od = {uop[u].second_source_operand[3:1], 1'b1};
         if (long_rd(uop[u].op)) begin
            b2[u] = {rf_q[u / PER_SIDE][od][HI_W-1:0], rf_q[u / PER_SIDE][ev]};
         end else if (uop[u].x2) begin
            b2[u] = {8'h00, rf_q[1 - u / PER_SIDE][uop[u].second_source_operand]};
         end else begin
            b2[u] = {8'h00, rf_q[u / PER_SIDE][uop[u].second_source_operand]};
         end
         case (uop[u].op)
            OP_ADD: res[u] = {8'h00, a1[u] + b2[u][XLEN-1:0]};
            OP_SUB: res[u] = {8'h00, a1[u] - b2[u][XLEN-1:0]};
            OP_ADDL: res[u] = {{HI_W{a1[u][XLEN-1]}}, a1[u]} + b2[u];
            OP_CMPGT: res[u] = {39'h0, $signed(a1[u]) > $signed(b2[u][XLEN-1:0])};
            OP_CMPGTL: res[u] = {39'h0,
                                 $signed({{HI_W{a1[u][XLEN-1]}}, a1[u]}) > $signed(b2[u])};
            OP_AND: res[u] = {8'h00, a1[u] & b2[u][XLEN-1:0]};
            OP_OR: res[u] = {8'h00, a1[u] | b2[u][XLEN-1:0]};
            OP_XOR: res[u] = {8'h00, a1[u] ^ b2[u][XLEN-1:0]};
            OP_LMBD: res[u] = {34'h0, lead_cnt(a1[u][0], b2[u], XLEN)};
            OP_NORM: res[u] = {34'h0, lead_cnt(b2[u][XLEN-1], b2[u], XLEN) - 6'h1};
            OP_NORML: res[u] = {34'h0, lead_cnt(b2[u][LLEN-1], b2[u], LLEN) - 6'h1};
            OP_SHL: res[u] = {8'h00, b2[u][XLEN-1:0] << a1[u][4:0]};
            OP_SHR: res[u] = {8'h00, $signed(b2[u][XLEN-1:0]) >>> a1[u][4:0]};
            OP_SHLL: res[u] = b2[u] << a1[u][5:0];
            OP_SHRL: res[u] = $signed(b2[u]) >>> a1[u][5:0];
            OP_MVK: res[u] = {{25{uop[u].imm[LOFF_W-1]}}, uop[u].imm};
            OP_MVCFR: res[u] = {8'h00, ctrl_q[uop[u].imm[CIDX_W-1:0]]};
            OP_MPY: res[u] = {8'h00, 32'($signed(a1[u][MUL_W-1:0])
                                        * $signed(b2[u][MUL_W-1:0]))};
            default: res[u] = '0;
         endcase
         // stores and loads scale the offset to words; only the b-side unit is long
         off = uop[u].op inside {OP_LDWK, OP_STWK} ? uop[u].imm
                                                   : {10'h000, uop[u].imm[SOFF_W-1:0]};
         ea[u] = b2[u][XLEN-1:0] + {15'h0000, off, 2'b00};
         wen[u] = ex[u] && !(uop[u].op inside {OP_NOP, OP_BR, OP_MVCTO, OP_LDW, OP_STW,
                                               OP_LDWK, OP_STWK, OP_CMPGT, OP_CMPGTL})
                  || ex[u] && uop[u].op inside {OP_CMPGT, OP_CMPGTL};
         wlong[u] = long_wr(uop[u].op);
         if (ex[u] && uop[u].op == OP_BR) begin
            br_d = 1'b1;
            br_tgt_d = b2[u][XLEN-1:0];
         end
      end
   end

   // writes land in the unit's own side only; no priority among units is
   // defined, a later loop index simply wins and the scheduler must avoid it
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         for (int s = 0; s < NSIDE; s++) begin
            for (int r = 0; r < NREG; r++) begin
               rf_q[s][r] <= '0;
            end
         end
      end else begin
         for (int u = 0; u < NUNIT; u++) begin
            if (wen[u] && wlong[u]) begin
               rf_q[u / PER_SIDE][{uop[u].dst[3:1], 1'b0}] <= res[u][XLEN-1:0];
               rf_q[u / PER_SIDE][{uop[u].dst[3:1], 1'b1}] <=
                  {24'h000000, res[u][LLEN-1:XLEN]};
            end else if (wen[u]) begin
               rf_q[u / PER_SIDE][uop[u].dst] <= res[u][XLEN-1:0];
            end
         end
         for (int s = 0; s < NSIDE; s++) begin
            if (ld_pend_q[s] && dmem_rvalid[s]) begin
               rf_q[s][ld_dst_q[s]] <= dmem_rdata[s];
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         for (int c = 0; c < CTRL_REGS; c++) begin
            ctrl_q[c] <= '0;
         end
      end else if (ex[MVC_UNIT] && uop[MVC_UNIT].op == OP_MVCTO) begin
         ctrl_q[uop[MVC_UNIT].imm[CIDX_W-1:0]] <= b2[MVC_UNIT][XLEN-1:0];
      end
   end

   // one outstanding load per side; a second load before the answer retargets it
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         for (int s = 0; s < NSIDE; s++) begin
            dmem_q[s] <= '0;
            ld_pend_q[s] <= 1'b0;
            ld_dst_q[s] <= '0;
         end
      end else begin
         for (int s = 0; s < NSIDE; s++) begin
            dmem_q[s].req <= 1'b0;
            dmem_q[s].we <= 1'b0;
            if (ld_pend_q[s] && dmem_rvalid[s]) begin
               ld_pend_q[s] <= 1'b0;
            end
            if (ex[s * PER_SIDE + U_D]
                && uop[s * PER_SIDE + U_D].op inside {OP_LDW, OP_STW, OP_LDWK, OP_STWK}) begin
               dmem_q[s] <= '{1'b1, uop[s * PER_SIDE + U_D].op inside {OP_STW, OP_STWK},
                              ea[s * PER_SIDE + U_D],
                              rf_q[s][uop[s * PER_SIDE + U_D].dst]};
               if (uop[s * PER_SIDE + U_D].op inside {OP_LDW, OP_LDWK}) begin
                  ld_pend_q[s] <= 1'b1;
                  ld_dst_q[s] <= uop[s * PER_SIDE + U_D].dst;
               end
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fetch_addr_q <= FETCH_RST;
         insn_valid_q <= 1'b0;
         insn_q <= '0;
      end else begin
         insn_valid_q <= fetch_valid;
         if (fetch_valid) begin
            insn_q <= fetch_data;
         end
         if (br_d) begin
            fetch_addr_q <= {br_tgt_d[XLEN-1:5], 3'h0};
         end else if (fetch_valid) begin
            fetch_addr_q <= fetch_addr_q + PKT_STEP;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fault_q <= '0;
      end else begin
         fault_q <= fault;
      end
   end

   assign fetch_addr = fetch_addr_q;
   assign insn_valid = insn_valid_q;
   assign insn = insn_q;
   assign dmem = dmem_q;
   assign unit_fault = fault_q;

   // checks
   default clocking a_clk @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   logic [3:0] a_odd0;
   logic [3:0] a_even0;
   logic [XLEN-1:0] a_res0;
   logic [XLEN-1:0] a_fold_a;
   logic [XLEN-1:0] a_fold_c;
   logic a_side_a_wr;
   assign a_odd0 = {uop[0].dst[3:1], 1'b1};
   assign a_even0 = {uop[0].dst[3:1], 1'b0};
   assign a_res0 = res[1][XLEN-1:0];
   assign a_side_a_wr = (|wen[3:0]) || (ld_pend_q[0] && dmem_rvalid[0]);
   always_comb begin
      a_fold_a = '0;
      a_fold_c = '0;
      for (int r = 0; r < NREG; r++) begin
         a_fold_a = a_fold_a ^ rf_q[0][r];
      end
      for (int c = 0; c < CTRL_REGS; c++) begin
         a_fold_c = a_fold_c ^ ctrl_q[c];
      end
   end

   a_long_fill: assert property (
      wen[0] && wlong[0] |=> rf_q[0][$past(a_odd0)][31:8] == 24'h000000)
      else $error("long write left upper odd bits set");
   a_long_low: assert property (
      wen[0] && wlong[0] && !ld_pend_q[0]
      |=> rf_q[0][$past(a_even0)] == $past(res[0][XLEN-1:0]))
      else $error("long write low word not in even register");
   a_own_port: assert property (
      wen[1] && !wlong[1] && wen[3:2] == 2'b00 && !wen[0] && !ld_pend_q[0]
      |=> rf_q[0][$past(uop[1].dst)] == $past(a_res0))
      else $error("shift unit write did not land");
   a_side_only: assert property (
      !a_side_a_wr |=> $stable(a_fold_a))
      else $error("side a file changed without a side a writer");
   a_cross_once: assert property (
      $onehot0(xuse[3:0]) && $onehot0(xuse[7:4]))
      else $error("two cross reads on one side");
   a_mvc_only_b: assert property (
      uop[1].valid && uop[1].op == OP_MVCTO && !ex[MVC_UNIT]
      |=> $stable(a_fold_c) && unit_fault[1])
      else $error("side a shift unit reached control registers");
   a_long_off: assert property (
      uop[3].valid && uop[3].op inside {OP_LDWK, OP_STWK}
      |=> unit_fault[3] && !dmem[0].req)
      else $error("side a address unit used a long offset");
   a_fetch_step: assert property (
      fetch_valid && !br_d |=> fetch_addr == $past(fetch_addr) + PKT_STEP)
      else $error("fetch address did not advance one packet");
   a_fetch_out: assert property (
      fetch_valid |=> insn_valid && insn == $past(fetch_data))
      else $error("fetched packet not delivered");

   c_all_write: cover property (&wen);
   c_long_b: cover property (wen[4] && wlong[4]);
   c_cross_both: cover property (|xuse[3:0] && |xuse[7:4]);
   c_load_back: cover property (ld_pend_q[1] && dmem_rvalid[1]);
endmodule : dsrf_top

/* File: test/dsrf_far_model.sv */
// far-side model: program memory and the two data memories that face the core
// assumes the bench raises fetch_en just after a clock edge; loads only, stores are dropped
`timescale 1ns/1ps
module dsrf_far_model #(
   parameter logic [31:0] LD_PAT = 32'hA5A50000
) (
   core_clk,
   nrst,
   dmem,
   dmem_rdata,
   dmem_rvalid,
   fetch_addr,
   fetch_en,
   fetch_valid,
   fetch_data
);
   import dsrf_pkg::*;
   input logic core_clk;
   input logic nrst;
   input dsrf_pkg::dsrf_dmem_s dmem [dsrf_pkg::NSIDE];
   output logic [dsrf_pkg::XLEN-1:0] dmem_rdata [dsrf_pkg::NSIDE];
   output logic dmem_rvalid [dsrf_pkg::NSIDE];
   input logic [dsrf_pkg::PADDR_W-1:0] fetch_addr;
   input logic fetch_en;
   output logic fetch_valid;
   output logic [dsrf_pkg::FETCH_W-1:0] fetch_data;

   logic [3:0] cnt_q [NSIDE];
   logic [XLEN-1:0] addr_q [NSIDE];

   // side a answers the cycle after a request, side b three cycles later still, so both paces are seen
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= '{default: '0};
         addr_q <= '{default: '0};
      end else begin
         for (int s = 0; s < NSIDE; s++) begin
            if (dmem[s].req && !dmem[s].we) begin
               cnt_q[s] <= 4'(1 + 3 * s);
               addr_q[s] <= dmem[s].addr;
            end else if (cnt_q[s] != 4'h0) begin
               cnt_q[s] <= cnt_q[s] - 4'h1;
            end
         end
      end
   end

   // outside an answer the words are inverted, so a stray sample never matches
   always_comb begin
      for (int s = 0; s < NSIDE; s++) begin
         dmem_rvalid[s] = (cnt_q[s] == 4'h1);
         dmem_rdata[s] = (addr_q[s] ^ LD_PAT) ^ {XLEN{~dmem_rvalid[s]}};
      end
      fetch_valid = fetch_en;
      for (int i = 0; i < NUNIT; i++) begin
         fetch_data[i*XLEN +: XLEN] = ({fetch_addr, 2'b00} + 32'(i)) ^ {XLEN{~fetch_en}};
      end
   end
endmodule : dsrf_far_model

/* File: test/tb.sv */
// bench for the two-sided register file: drives decoded ops, judges stores and fetches
// assumes the far-side model answers loads and fetches; registers are seen through stores
`timescale 1ns/1ps
module tb;
   import dsrf_pkg::*;
   localparam logic [31:0] LD_PAT = 32'hA5A50000;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic fetch_en = 1'b0;
   dsrf_uop_s u [NUNIT] = '{default: '0};
   dsrf_uop_s nx [NUNIT] = '{default: '0};
   logic fetch_valid;
   logic [FETCH_W-1:0] fetch_data;
   logic [PADDR_W-1:0] fetch_addr;
   logic insn_valid;
   logic [NUNIT-1:0][XLEN-1:0] insn;
   dsrf_dmem_s dmem [NSIDE];
   logic [XLEN-1:0] dmem_rdata [NSIDE];
   logic dmem_rvalid [NSIDE];
   logic [NUNIT-1:0] unit_fault;
   int err_count = 0;
   int total_checks = 0;

   always #2.5 core_clk = ~core_clk;

   dsrf_top i_dsrf_top (.core_clk(core_clk), .nrst(nrst), .uop(u), .fetch_valid(fetch_valid),
      .fetch_data(fetch_data), .fetch_addr(fetch_addr), .insn_valid(insn_valid), .insn(insn),
      .dmem(dmem), .dmem_rdata(dmem_rdata), .dmem_rvalid(dmem_rvalid), .unit_fault(unit_fault));
   dsrf_far_model #(.LD_PAT(LD_PAT)) i_dsrf_far_model (.core_clk(core_clk), .nrst(nrst),
      .dmem(dmem), .dmem_rdata(dmem_rdata), .dmem_rvalid(dmem_rvalid), .fetch_addr(fetch_addr),
      .fetch_en(fetch_en), .fetch_valid(fetch_valid), .fetch_data(fetch_data));

   task automatic finish_test();
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   function automatic dsrf_uop_s mk(input dsrf_op_e op, input logic [3:0] d,
         input logic [3:0] a, input logic [3:0] b, input logic [14:0] imm);
      mk = '0;
      mk.valid = 1'b1;
      mk.op = op;
      mk.dst = d;
      mk.first_source_operand = a;
      mk.second_source_operand = b;
      mk.imm = imm;
   endfunction : mk

   // staged ops go out once per edge, so no input is assigned twice in one step
   task automatic go();
      u = nx;
      nx = '{default: '0};
      @(posedge core_clk);
      #1;
   endtask : go

   task automatic setr(input int k, input logic [3:0] d, input logic [14:0] imm);
      nx[k] = mk(OP_MVK, d, 4'h0, 4'h0, imm);
      go();
   endtask : setr

   // register 15 of each side is the store base: 0x100 on a, 0x200 on b
   task automatic st_chk(input int s, input logic [3:0] r, input logic [31:0] exp);
      nx[4 * s + 3] = mk(OP_STW, r, 4'h0, 4'hF, {11'h0, r});
      go();
      chk(32'({dmem[s].req, dmem[s].we}), 32'h3);
      chk(dmem[s].addr, (32'h100 << s) + {26'h0, r, 2'b00});
      chk(dmem[s].wdata, exp);
   endtask : st_chk

   task automatic wait_rv(input int s);
      int n = 0;
      while (dmem_rvalid[s] !== 1'b1 && n < 10) begin
         go();
         n++;
      end
      chk(32'(dmem_rvalid[s]), 32'h1);
      if (dmem_rvalid[s] !== 1'b1) finish_test();
   endtask : wait_rv

   task automatic t_fetch();
      fetch_en = 1'b1;
      go();
      for (int i = 0; i < NUNIT; i++) chk(insn[i], 32'(i));
      chk(32'({insn_valid, fetch_addr}), {2'b01, 30'h8});
      go();
      chk(insn[5], 32'h25);
      chk(32'(fetch_addr), 32'h10);
      fetch_en = 1'b0;
      nx[1] = mk(OP_BR, 4'h0, 4'h0, 4'hF, 15'h0);
      go();
      chk(32'(insn_valid), 32'h0);
      chk(insn[7], 32'h27);
      chk(32'(fetch_addr), 32'h40);
   endtask : t_fetch

   task automatic t_files();
      for (int s = 0; s < NSIDE; s++) begin
         nx[4 * s] = mk(OP_ADD, 4'h1, 4'hF, 4'hF, 15'h0);
         nx[4 * s + 1] = mk(OP_MVK, 4'h2, 4'h0, 4'h0, 15'h4000 + 15'(s));
         nx[4 * s + 2] = mk(OP_MPY, 4'h3, 4'hF, 4'hF, 15'h0);
         nx[4 * s + 3] = mk(OP_SUB, 4'h4, 4'hF, 4'h0, 15'h0);
      end
      go();
      for (int s = 0; s < NSIDE; s++) begin
         st_chk(s, 4'h1, 32'h200 << s);
         st_chk(s, 4'h2, 32'hFFFFC000 + 32'(s));
         st_chk(s, 4'h3, 32'h10000 << (2 * s));
         st_chk(s, 4'h4, 32'h100 << s);
      end
   endtask : t_files

   task automatic t_long();
      setr(1, 4'h1, 15'h0001);
      setr(1, 4'h4, 15'h7FFF);
      setr(1, 4'h5, 15'h3F01);
      setr(1, 4'h3, 15'h7FFF);
      setr(1, 4'h7, 15'h7FFF);
      nx[0] = mk(OP_ADDL, 4'h2, 4'h1, 4'h4, 15'h0);
      go();
      nx[1] = mk(OP_SHLL, 4'h6, 4'h1, 4'h2, 15'h0);
      go();
      st_chk(0, 4'h2, 32'h0);
      st_chk(0, 4'h3, 32'h2);
      st_chk(0, 4'h6, 32'h0);
      st_chk(0, 4'h7, 32'h4);
   endtask : t_long

   task automatic t_load();
      nx[3] = mk(OP_LDW, 4'h5, 4'h0, 4'hF, 15'h0003);
      nx[7] = mk(OP_LDWK, 4'h5, 4'h0, 4'hF, 15'h1000);
      go();
      chk(32'({dmem[0].req, dmem[0].we, dmem[1].req, dmem[1].we}), 32'hA);
      chk(dmem[0].addr, 32'h10C);
      chk(dmem[1].addr, 32'h4200);
      wait_rv(0);
      wait_rv(1);
      go();
      st_chk(0, 4'h5, 32'h10C ^ LD_PAT);
      st_chk(1, 4'h5, 32'h4200 ^ LD_PAT);
   endtask : t_load

   task automatic t_fault();
      nx[1] = mk(OP_MVCTO, 4'h0, 4'h0, 4'hF, 15'h3);
      nx[5] = mk(OP_MVCTO, 4'h0, 4'h0, 4'hF, 15'h3);
      nx[3] = mk(OP_LDWK, 4'h6, 4'h0, 4'hF, 15'h0);
      go();
      chk(32'({unit_fault, dmem[0].req}), 32'h14);
      nx[5] = mk(OP_MVCFR, 4'h8, 4'h0, 4'h0, 15'h3);
      go();
      nx[5] = mk(OP_ADD, 4'h9, 4'hF, 4'hF, 15'h0);
      nx[5].x2 = 1'b1;
      nx[6] = mk(OP_MPY, 4'hA, 4'hF, 4'hF, 15'h0);
      nx[6].x2 = 1'b1;
      nx[0] = mk(OP_ADD, 4'hC, 4'hF, 4'hF, 15'h0);
      nx[0].x1 = 1'b1;
      nx[0].x2 = 1'b1;
      go();
      chk(32'(unit_fault), 32'h41);
      st_chk(1, 4'h8, 32'h200);
      st_chk(1, 4'h9, 32'h300);
      st_chk(1, 4'hA, 32'h0);
   endtask : t_fault

   // bit counts on both sides, a compare and a shift on side b, then a long-offset store on side b
   task automatic t_ops();
      setr(5, 4'h6, 15'h0004);
      nx[0] = mk(OP_LMBD, 4'h8, 4'h2, 4'h7, 15'h0);
      nx[1] = mk(OP_XOR, 4'h9, 4'hF, 4'h7, 15'h0);
      nx[4] = mk(OP_CMPGT, 4'hC, 4'hF, 4'h2, 15'h0);
      nx[5] = mk(OP_SHR, 4'hD, 4'h6, 4'h2, 15'h0);
      go();
      nx[0] = mk(OP_NORM, 4'hA, 4'h0, 4'h7, 15'h0);
      nx[4] = mk(OP_NORML, 4'hE, 4'h0, 4'h2, 15'h0);
      go();
      st_chk(0, 4'h8, 32'h1D);
      st_chk(0, 4'h9, 32'h104);
      st_chk(0, 4'hA, 32'h1C);
      st_chk(1, 4'hC, 32'h1);
      st_chk(1, 4'hD, 32'hFFFFFC00);
      nx[7] = mk(OP_STWK, 4'hE, 4'h0, 4'hF, 15'h0010);
      go();
      chk(dmem[1].addr, 32'h240);
      chk(dmem[1].wdata, 32'h7);
   endtask : t_ops

   // a0 is never written, so it holds zero as a condition source
   task automatic t_cond();
      nx[1] = mk(OP_MVK, 4'hB, 4'h0, 4'h0, 15'h5);
      nx[1].cond_en = 1'b1;
      nx[5] = mk(OP_MVK, 4'hB, 4'h0, 4'h0, 15'h6);
      nx[5].cond_en = 1'b1;
      nx[5].cond_z = 1'b1;
      go();
      chk(32'(unit_fault), 32'h0);
      st_chk(0, 4'hB, 32'h0);
      st_chk(1, 4'hB, 32'h6);
   endtask : t_cond

   initial begin
      repeat (6) @(posedge core_clk);
      #1;
      nrst = 1'b1;
      chk(32'(fetch_addr), 32'h0);
      chk(32'({insn_valid, unit_fault}), 32'h0);
      chk(32'({dmem[0].req, dmem[1].req}), 32'h0);
      nx[1] = mk(OP_MVK, 4'hF, 4'h0, 4'h0, 15'h0100);
      nx[5] = mk(OP_MVK, 4'hF, 4'h0, 4'h0, 15'h0200);
      go();
      t_fetch();
      t_files();
      t_long();
      t_load();
      t_fault();
      t_ops();
      t_cond();
      finish_test();
   end
endmodule : tb
